// *** black_level_offset_control_tb.sv ***
`timescale 1ns/100ps
module black_level_offset_control_tb;
   logic ref_clk_i;
   logic resetn_i;
   blo_pkg::blo_wr_t wr;
   logic [7:0] rd_addr, rd_data, v, cdelay, clen, m;
   logic hsync, vsync, sep_vsync, slicer, power_down_ctl, tsel;
   logic [29:0] adc;
   logic [26:0] corr;
   logic [2:0] sact, sbw;
   logic clamp, swin, coast_in, slc_out, pd_force, pd_level, boost;
   logic [1:0] ddrv, cdrv;
   logic [8:0] trim_exp [3];
   logic [31:0] lfsr;
   int error_cnt, tests_run, k, cl_cnt, sw_cnt;

   blo_ctrl #(.CHANNELS(3)) DUT (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
      .wr_i(wr), .rd_addr_i(rd_addr), .rd_data_o(rd_data),
      .hsync_pin_i(hsync), .vsync_pin_i(vsync), .sep_vsync_i(sep_vsync),
      .slicer_i(slicer), .power_down_ctl_i(power_down_ctl), .clamp_target_sel_i(tsel),
      .clamp_delay_i(cdelay), .clamp_length_i(clen), .adc_data_i(adc),
      .applied_corr_o(corr), .servo_active_o(sact), .clamp_o(clamp),
      .servo_window_o(swin), .coast_in_o(coast_in),
      .slicer_out_pin_o(slc_out), .pd_force_o(pd_force),
      .pd_level_o(pd_level), .data_drive_o(ddrv), .clock_drive_o(cdrv),
      .servo_bandwidth_o(sbw), .boost_o(boost));
   blo_host_model u_host (.ref_clk_i(ref_clk_i), .wr_o(wr),
      .rd_addr_o(rd_addr), .rd_data_i(rd_data));

   initial begin
      ref_clk_i = 1'b0;
      forever #12.5 ref_clk_i = ~ref_clk_i;
   end

   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr_next
   function automatic logic exp_slicer(input logic [7:0] cfg,
         input logic pd_n, input logic slc, input logic hs);
      if (!pd_n) return cfg[0];
      return (cfg[1] ? hs : slc) ^ cfg[2];
   endfunction : exp_slicer

   task automatic check(input string name, input logic [31:0] exp,
         input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask : check
   task automatic rd_check(input string name, input logic [7:0] addr,
         input logic [7:0] exp);
      logic [7:0] d;
      u_host.read_reg(addr, d);
      check(name, 32'(exp), 32'(d));
   endtask : rd_check
   task automatic settle(input int n);
      repeat (n) @(negedge ref_clk_i);
   endtask : settle
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : report_and_stop

   // The whole sequence needs a few hundred cycles; this leaves wide margin.
   initial begin
      repeat (20000) @(posedge ref_clk_i);
      error_cnt++;
      $display("mismatch watchdog expected done seen timeout");
      report_and_stop();
   end

   initial begin
      error_cnt = 0;
      tests_run = 0;
      lfsr = 32'h1915;
      {hsync, vsync, sep_vsync, slicer, tsel} = 5'h00;
      power_down_ctl = 1'b1;
      cdelay = 8'h04;
      clen = 8'h0a;
      adc = 30'h0;
      trim_exp = '{9'h0ff, 9'h0ff, 9'h0ff};
      resetn_i = 1'b0;
      settle(5);
      resetn_i = 1'b1;
      for (int c = 0; c < 3; c++) check("corr_rst", 32'h0ff, 32'(corr[c*9 +: 9]));
      rd_check("pre_coast", blo_pkg::ADDR_CPRE, 8'h00);
      rd_check("post_coast", blo_pkg::ADDR_CPOST, 8'h00);
      rd_check("coast_rst", blo_pkg::ADDR_COAST, blo_pkg::RST_COAST);
      rd_check("rsv_a", blo_pkg::ADDR_RSV_A, blo_pkg::RST_RSV_A);
      rd_check("rsv_b", blo_pkg::ADDR_RSV_B, blo_pkg::RST_ZERO);
      u_host.write_reg(8'h30, 8'hff);
      rd_check("unmapped", 8'h30, 8'h00);
      // Manual trim path, with the extreme codes first.
      u_host.write_reg(blo_pkg::ADDR_SERVO, 8'h04);
      settle(3);
      check("servo_off", 32'h0, 32'(sact));
      for (int i = 0; i < 5; i++) begin
         lfsr = lfsr_next(lfsr);
         adc = lfsr[29:0];
         k = int'(lfsr[3:0]) % 3;
         v = lfsr[15:8];
         u_host.write_reg(8'(blo_pkg::ADDR_TRIM_FIRST + 8'(2 * k)),
            {7'h00, (i == 1) | (i > 1 && lfsr[5])});
         settle(3);
         check("trim_hi", 32'(trim_exp[k]), 32'(corr[k*9 +: 9]));
         trim_exp[k] = (i == 0) ? 9'h000 : (i == 1) ? 9'h1ff : {lfsr[5], v};
         u_host.write_reg(8'(blo_pkg::ADDR_TRIM_FIRST + 8'(2 * k + 1)),
            trim_exp[k][7:0]);
         settle(3);
         check("trim_lo", 32'(trim_exp[k]), 32'(corr[k*9 +: 9]));
      end
      // Target 1f8h is -2 LSB, inside the minimum-level range.
      u_host.write_reg(blo_pkg::ADDR_TGT_FIRST, 8'h01);
      rd_check("tgt_hi", blo_pkg::ADDR_TGT_FIRST, 8'h00);
      u_host.write_reg(8'(blo_pkg::ADDR_TGT_FIRST + 8'h01), 8'hf8);
      rd_check("tgt_act", blo_pkg::ADDR_TGT_FIRST, 8'h01);
      for (int b = 0; b < 8; b++) begin
         v = {3'(b), 2'(b), 3'b100};
         u_host.write_reg(blo_pkg::ADDR_SERVO, v);
         settle(3);
         check("bandwidth", 32'(b), 32'(sbw));
         rd_check("servo_rd", blo_pkg::ADDR_SERVO, v);
      end
      for (int i = 0; i < 4; i++) begin
         lfsr = lfsr_next(lfsr);
         v = (i == 0) ? 8'h50 : lfsr[7:0];
         u_host.write_reg(blo_pkg::ADDR_DRIVE, v);
         settle(3);
         check("data_drive", 32'(v[7:6]), 32'(ddrv));
         check("clock_drive", 32'(v[5:4]), 32'(cdrv));
      end
      // Every source, invert and level combination, pins drawn at random.
      for (int i = 0; i < 16; i++) begin
         lfsr = lfsr_next(lfsr);
         {hsync, vsync, sep_vsync, slicer} = lfsr[3:0];
         power_down_ctl = lfsr[4] | (i < 8);
         v = {1'b0, 1'(i >> 3), 3'b011, 3'(i)};
         u_host.write_coast(v);
         settle(5);
         check("slicer_pin", 32'(exp_slicer(v, power_down_ctl, slicer, hsync)),
            32'(slc_out));
         check("coast_in", 32'(v[6] ? sep_vsync : vsync), 32'(coast_in));
         check("pd_force", 32'(!power_down_ctl), 32'(pd_force));
         if (!power_down_ctl) check("pd_level", 32'(v[0]), 32'(pd_level));
      end
      {hsync, vsync, sep_vsync, slicer} = 4'h0;
      power_down_ctl = 1'b1;
      u_host.write_reg(blo_pkg::ADDR_SERVO, 8'h00);
      for (int i = 0; i < 3; i++) begin
         m = (i == 0) ? 8'h00 : (i == 1) ? 8'h03 : 8'(clen - 8'h01);
         u_host.write_clamp_only(m, clen);
         settle(20);
         hsync = 1'b1;
         settle(4);
         hsync = 1'b0;
         cl_cnt = 0;
         sw_cnt = 0;
         repeat (60) begin
            @(negedge ref_clk_i);
            cl_cnt += int'(clamp === 1'b1);
            sw_cnt += int'(swin === 1'b1);
         end
         if (m == 8'h00) check("clamp_len", 32'(clen), 32'(cl_cnt));
         else begin
            check("clamp_part", 32'(m), 32'(cl_cnt));
            check("servo_part", 32'(clen - m), 32'(sw_cnt));
         end
      end
      // Servo on: the first target is in range and the measured black sits
      // above it, so each hsync steps the integrator up by one.
      check("servo_on", 32'h1, 32'(sact));
      check("servo_corr", 32'h101, 32'(corr[8:0]));
      for (int i = 0; i < 2; i++) begin
         u_host.write_reg(blo_pkg::ADDR_SERVO, (i == 0) ? 8'h02 : 8'h01);
         repeat (2) begin
            hsync = 1'b1;
            settle(4);
            hsync = 1'b0;
            settle(4);
         end
         check("servo_hold", 32'h102, 32'(corr[8:0]));
      end
      // Error of -2 LSB: outside a 1 LSB window, inside a 2 LSB one.
      adc = 30'h0;
      for (int i = 4; i < 6; i++) begin
         u_host.write_reg(blo_pkg::ADDR_SETTLE, 8'(i << 1));
         settle(3);
         check("boost", 32'(i == 4), 32'(boost));
      end
      report_and_stop();
   end
endmodule : black_level_offset_control_tb

// *** blo_ctrl.sv ***
`timescale 1ns/100ps
// Behaviour
// RULE1: Nine-bit per-channel trim, 0ffh is zero.
// RULE2: Quarter-LSB steps; above center subtracts.
// RULE3: Trim used only when servo disabled.
// RULE4: Trim high write latent until low write.
// RULE5: Target high write latent until low write.
// RULE6: Minimum level target two's complement, range limited.
// RULE7: Center level target 120 to 135 allowed.
// RULE8: Signed three-bit servo bandwidth setting.
// RULE9: Coring dead band per two-bit code.
// RULE10: Disable bit selects servo or manual trim.
// RULE11: Freeze bit holds servo state.
// RULE12: Applied correction per hsync or 64 vsyncs.
// RULE13: Integrator updates every hsync regardless.
// RULE14: Coast source from vsync pin or separator.
// RULE15: Host writes ones to bits four, three.
// RULE16: Slicer pin source select and invert.
// RULE17: Power-down forces outputs to fixed level.
// RULE18: Clamp split: first m clamp, rest servo.
// RULE19: Host keeps clamp-only count below length.
// RULE20: Clamp coasted hsyncs before and after vsync.
// RULE21: Drive fields: tri-state, quarter, full.
// RULE22: Settle window stops bandwidth boosting.
// RULE23: Clamp starts delay after hsync, lasts length.
// RULE24: Host avoids out-of-range target codes.
module blo_ctrl #(
   parameter int CHANNELS = 3
) (
   // Clock and reset.
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   // Register write and read ports from the serial interface.
   input wire blo_pkg::blo_wr_t wr_i,
   input wire logic [7:0] rd_addr_i,
   output logic [7:0] rd_data_o,
   // Sync, slicer and mode pins.
   input wire logic hsync_pin_i,
   input wire logic vsync_pin_i,
   input wire logic sep_vsync_i,
   input wire logic slicer_i,
   input wire logic power_down_ctl_i,
   input wire logic clamp_target_sel_i,
   input wire logic [7:0] clamp_delay_i,
   input wire logic [7:0] clamp_length_i,
   // Converter data and correction.
   input wire logic [CHANNELS*10-1:0] adc_data_i,
   output logic [CHANNELS*9-1:0] applied_corr_o,
   output logic [CHANNELS-1:0] servo_active_o,
   // Control outputs.
   output logic clamp_o,
   output logic servo_window_o,
   output logic coast_in_o,
   output logic slicer_out_pin_o,
   output logic pd_force_o,
   output logic pd_level_o,
   output logic [1:0] data_drive_o,
   output logic [1:0] clock_drive_o,
   output logic [2:0] servo_bandwidth_o,
   output logic boost_o
);
   localparam int N6 = 2 * CHANNELS;
   logic [7:0] lo_r [N6];
   logic [N6-1:0] hi_pend_r;
   logic [N6-1:0] hi_act_r;
   blo_pkg::blo_servo_t servo_r;
   blo_pkg::blo_coast_t coast_r;
   logic [7:0] clamp_only_r, cpre_r, cpost_r, settle_r, rsva_r, rsvb_r;
   blo_pkg::blo_drive_t drive_r;
   logic [2:0] hs_s, vs_s, sv_s, sl_s, pd_s;
   logic hs_rise, hs_fall, vs_rise, coast_vs;
   logic [8:0] integ_r [CHANNELS];
   logic [8:0] corr_r [CHANNELS];
   logic [blo_pkg::FCNT_W-1:0] frame_cnt_r;
   logic [8:0] clamp_cnt_r;
   logic clamp_run_r;
   logic [7:0] line_cnt_r, post_cnt_r;
   logic post_run_r;

   // Register index for the two halves of a trim or target pair.
   function automatic int pair_idx(input logic [7:0] a, input logic [7:0] b);
      return int'(a - b);
   endfunction : pair_idx

   // Sync inputs come from pins; the third stage only feeds edge detect.
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         hs_s <= 3'h0;
         vs_s <= 3'h0;
         sv_s <= 3'h0;
         sl_s <= 3'h0;
         pd_s <= 3'h0;
      end else begin
         hs_s <= {hs_s[1:0], hsync_pin_i};
         vs_s <= {vs_s[1:0], vsync_pin_i};
         sv_s <= {sv_s[1:0], sep_vsync_i};
         sl_s <= {sl_s[1:0], slicer_i};
         pd_s <= {pd_s[1:0], power_down_ctl_i};
      end
   end
   assign hs_rise = hs_s[1] & ~hs_s[2];
   assign hs_fall = ~hs_s[1] & hs_s[2];
   // Coast generator input follows the selected vsync source. [RULE14]
   assign coast_vs = coast_r.coast_source_sel ? sv_s[1] : vs_s[1];
   assign vs_rise = coast_vs & ~(coast_r.coast_source_sel ? sv_s[2] : vs_s[2]);

   // Trim and target pairs: the high bit waits until the low byte lands.
   genvar g;
   generate
      for (g = 0; g < N6; g++) begin : g_pair
         always_ff @(posedge ref_clk_i or negedge resetn_i) begin
            if (!resetn_i) begin
               lo_r[g] <= 8'hff;
               hi_pend_r[g] <= 1'b0;
               hi_act_r[g] <= 1'b0;
            end else if (wr_i.we) begin
               if (pair_idx(wr_i.addr, blo_pkg::ADDR_TRIM_FIRST) == 2*g
                  || pair_idx(wr_i.addr, blo_pkg::ADDR_TGT_FIRST)
                     == 2*(g-CHANNELS) && g >= CHANNELS)
                  hi_pend_r[g] <= wr_i.data[0]; // [RULE4] [RULE5]
               if (pair_idx(wr_i.addr, blo_pkg::ADDR_TRIM_FIRST) == 2*g+1
                  || pair_idx(wr_i.addr, blo_pkg::ADDR_TGT_FIRST)
                     == 2*(g-CHANNELS)+1 && g >= CHANNELS) begin
                  lo_r[g] <= wr_i.data;
                  hi_act_r[g] <= hi_pend_r[g]; // [RULE4] [RULE5]
               end
            end
         end
      end
   endgenerate

   // Single control registers.
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         servo_r <= '0;
         coast_r <= blo_pkg::RST_COAST;
         clamp_only_r <= blo_pkg::RST_ZERO;
         cpre_r <= blo_pkg::RST_ZERO; // [RULE20]
         cpost_r <= blo_pkg::RST_ZERO; // [RULE20]
         drive_r <= '0;
         settle_r <= blo_pkg::RST_ZERO;
         rsva_r <= blo_pkg::RST_RSV_A;
         rsvb_r <= blo_pkg::RST_ZERO;
      end else if (wr_i.we) begin
         case (wr_i.addr)
            blo_pkg::ADDR_SERVO: servo_r <= wr_i.data;
            blo_pkg::ADDR_COAST: coast_r <= wr_i.data;
            blo_pkg::ADDR_CLAMP_ONLY: clamp_only_r <= wr_i.data;
            blo_pkg::ADDR_CPRE: cpre_r <= wr_i.data;
            blo_pkg::ADDR_CPOST: cpost_r <= wr_i.data;
            blo_pkg::ADDR_DRIVE: drive_r <= wr_i.data;
            blo_pkg::ADDR_SETTLE: settle_r <= wr_i.data;
            blo_pkg::ADDR_RSV_A: rsva_r <= wr_i.data;
            blo_pkg::ADDR_RSV_B: rsvb_r <= wr_i.data;
            default: ;
         endcase
      end
   end

   // Read-back returns stored bytes; trim and target high reads show live bit.
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rd_data_o <= 8'h00;
      end else begin
         rd_data_o <= 8'h00;
         for (int k = 0; k < N6; k++) begin
            if (rd_addr_i == blo_pkg::ADDR_TRIM_FIRST + 8'(2*k))
               rd_data_o <= {7'h0, hi_act_r[k]};
            if (rd_addr_i == blo_pkg::ADDR_TRIM_FIRST + 8'(2*k+1))
               rd_data_o <= lo_r[k];
         end
         case (rd_addr_i)
            blo_pkg::ADDR_SERVO: rd_data_o <= servo_r;
            blo_pkg::ADDR_COAST: rd_data_o <= coast_r;
            blo_pkg::ADDR_CLAMP_ONLY: rd_data_o <= clamp_only_r;
            blo_pkg::ADDR_CPRE: rd_data_o <= cpre_r;
            blo_pkg::ADDR_CPOST: rd_data_o <= cpost_r;
            blo_pkg::ADDR_DRIVE: rd_data_o <= drive_r;
            blo_pkg::ADDR_SETTLE: rd_data_o <= settle_r;
            blo_pkg::ADDR_RSV_A: rd_data_o <= rsva_r;
            blo_pkg::ADDR_RSV_B: rd_data_o <= rsvb_r;
            default: ;
         endcase
      end
   end

   // Clamp generator with coasting around vsync.
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         clamp_cnt_r <= 9'h000;
         clamp_run_r <= 1'b0;
         clamp_o <= 1'b0;
         servo_window_o <= 1'b0;
      end else begin
         if (hs_fall) begin
            clamp_cnt_r <= 9'h000;
            clamp_run_r <= 1'b1;
         end else if (clamp_run_r) begin
            clamp_cnt_r <= clamp_cnt_r + 9'h001;
         end
         if (clamp_run_r && clamp_cnt_r
             >= {1'b0, clamp_delay_i} + {1'b0, clamp_length_i})
            clamp_run_r <= 1'b0;
         // Window opens after delay and lasts clamp_length. [RULE23]
         if (clamp_run_r && clamp_cnt_r >= {1'b0, clamp_delay_i}
             && clamp_cnt_r < {1'b0, clamp_delay_i} + {1'b0, clamp_length_i}
             && !(post_run_r || line_cnt_r < cpre_r)) begin // [RULE20]
            // First m pixels clamp, rest is servo time. [RULE18]
            if (clamp_only_r != 8'h00 && clamp_cnt_r
                >= {1'b0, clamp_delay_i} + {1'b0, clamp_only_r}) begin
               clamp_o <= 1'b0;
               servo_window_o <= 1'b1;
            end else begin
               clamp_o <= 1'b1;
               servo_window_o <= (clamp_only_r == 8'h00);
            end
         end else begin
            clamp_o <= 1'b0;
            servo_window_o <= 1'b0;
         end
      end
   end

   // Line counters: pre-coast counts lines left before an assumed vsync
   // using the last frame's length; post-coast counts lines after it.
   logic [7:0] lines_since_r, frame_len_r;
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         line_cnt_r <= 8'hff;
         lines_since_r <= 8'h00;
         frame_len_r <= 8'hff;
         post_cnt_r <= 8'h00;
         post_run_r <= 1'b0;
      end else begin
         if (vs_rise) begin
            frame_len_r <= lines_since_r;
            lines_since_r <= 8'h00;
            post_cnt_r <= cpost_r;
            post_run_r <= (cpost_r != 8'h00); // [RULE20]
         end else if (hs_rise) begin
            if (lines_since_r != 8'hff)
               lines_since_r <= lines_since_r + 8'h01;
            if (post_run_r) begin
               post_cnt_r <= post_cnt_r - 8'h01;
               post_run_r <= (post_cnt_r > 8'h01);
            end
         end
         line_cnt_r <= frame_len_r - lines_since_r; // [RULE20]
      end
   end

   // Servo integrators and applied correction.
   generate
      for (g = 0; g < CHANNELS; g++) begin : g_servo
         logic [8:0] target;
         logic [11:0] err;
         logic [9:0] adc;
         logic in_range, cored;
         assign target = {hi_act_r[CHANNELS+g], lo_r[CHANNELS+g]};
         assign adc = adc_data_i[g*10 +: 10];
         // Allowed target windows per clamp level. [RULE6] [RULE7]
         assign in_range = clamp_target_sel_i
            ? ($signed(target) >= $signed(blo_pkg::TGT_CTR_LO)
               && $signed(target) <= $signed(blo_pkg::TGT_CTR_HI))
            : ($signed(target) >= $signed(blo_pkg::TGT_MIN_LO)
               && $signed(target) <= $signed(blo_pkg::TGT_MIN_HI));
         // Error in quarter LSB: target minus measured black. [RULE6]
         assign err = {{3{target[8]}}, target} - {2'b00, adc}
                    + (clamp_target_sel_i ? blo_pkg::CTR_LEVEL_Q : 12'h000);
         // Coring thresholds 0, 1, 6, 4 quarter-LSB. [RULE9]
         always_comb begin
            case (servo_r.coring_range)
               2'b00: cored = 1'b0;
               2'b01: cored = ($signed(err) >= -9'sd1 && $signed(err) <= 9'sd1);
               2'b10: cored = ($signed(err) >= -9'sd6 && $signed(err) <= 9'sd6);
               2'b11: cored = ($signed(err) >= -9'sd4 && $signed(err) <= 9'sd4);
               default: cored = 1'b0;
            endcase
         end
         always_ff @(posedge ref_clk_i or negedge resetn_i) begin
            if (!resetn_i) begin
               integ_r[g] <= blo_pkg::TRIM_CENTER;
               corr_r[g] <= blo_pkg::TRIM_CENTER;
               servo_active_o[g] <= 1'b0;
            end else begin
               servo_active_o[g] <= ~servo_r.servo_disable & in_range;
               // Integrator steps each hsync unless disabled, frozen, out of range or inside the coring band. [RULE11] [RULE13]
               if (hs_rise && !servo_r.servo_disable && !servo_r.servo_freeze
                   && in_range && !cored)
                  integ_r[g] <= $signed(err) > 0 ? integ_r[g] - 9'h001
                                               : integ_r[g] + 9'h001;
               if (servo_r.servo_disable) // [RULE3] [RULE10]
                  corr_r[g] <= {hi_act_r[g], lo_r[g]}; // [RULE1] [RULE2]
               else if (servo_r.frame_update ? (vs_rise && frame_cnt_r == '0)
                        : hs_rise) // [RULE12]
                  corr_r[g] <= integ_r[g];
            end
         end
         assign applied_corr_o[g*9 +: 9] = corr_r[g];
      end
   endgenerate

   // Frame-paced counter wraps every 64 vsyncs.
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i)
         frame_cnt_r <= '0;
      else if (vs_rise)
         frame_cnt_r <= frame_cnt_r + 1'b1; // [RULE12]
   end

   logic [11:0] err_mag0;
   assign err_mag0 = g_servo[0].err[11] ? -g_servo[0].err : g_servo[0].err;
   // Pin level outputs, all registered.
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         coast_in_o <= 1'b0;
         slicer_out_pin_o <= 1'b0;
         pd_force_o <= 1'b0;
         pd_level_o <= 1'b0;
         data_drive_o <= 2'b00;
         clock_drive_o <= 2'b00;
         servo_bandwidth_o <= 3'b000;
         boost_o <= 1'b0;
      end else begin
         coast_in_o <= coast_vs; // [RULE14]
         // Power-down level overrides the slicer pin too. [RULE17]
         slicer_out_pin_o <= !pd_s[1] ? coast_r.powerdown_out_level
            : (coast_r.slicer_out_source ? hs_s[1] : sl_s[1])
              ^ coast_r.slicer_out_invert; // [RULE16]
         pd_force_o <= !pd_s[1]; // [RULE17]
         pd_level_o <= coast_r.powerdown_out_level; // [RULE17]
         data_drive_o <= drive_r.data_drive; // [RULE21]
         clock_drive_o <= drive_r.clock_drive; // [RULE21]
         servo_bandwidth_o <= servo_r.servo_bandwidth_sel; // [RULE8]
         // Boost only while error exceeds the settle window. [RULE22]
         boost_o <= settle_r[3:1] != 3'b000 && !servo_r.servo_disable
            && err_mag0 > (settle_r[3] && settle_r[2:1] != 2'b00
               ? {7'h00, 3'(settle_r[3:1] - 3'h3), 2'b00}
               : {9'h000, settle_r[3:1]});
      end
   end

   chk_trim_latent: assert property (@(posedge ref_clk_i) disable iff
      (!resetn_i) wr_i.we && wr_i.addr == blo_pkg::ADDR_TRIM_FIRST
      |=> $stable(hi_act_r[0])) else $error("trim high took effect early"); // [RULE4]
   chk_manual_trim: assert property (@(posedge ref_clk_i) disable iff
      (!resetn_i) servo_r.servo_disable ##1 servo_r.servo_disable
      |-> corr_r[0] == {hi_act_r[0], lo_r[0]} || $changed(lo_r[0])
      || $changed(hi_act_r[0])) else $error("manual trim not applied"); // [RULE10]
   chk_freeze_hold: assert property (@(posedge ref_clk_i) disable iff
      (!resetn_i) servo_r.servo_freeze && $past(servo_r.servo_freeze)
      |-> $stable(integ_r[0])) else $error("frozen servo moved"); // [RULE11]
   chk_slicer_sel: assert property (@(posedge ref_clk_i) disable iff
      (!resetn_i) pd_s[1] && !coast_r.slicer_out_source
      && !coast_r.slicer_out_invert && $stable(coast_r)
      |=> slicer_out_pin_o == $past(sl_s[1])) else $error("slicer route"); // [RULE16]
   chk_pd_level: assert property (@(posedge ref_clk_i) disable iff
      (!resetn_i) !pd_s[1] |=> pd_force_o && slicer_out_pin_o ==
      $past(coast_r.powerdown_out_level)) else $error("power-down level"); // [RULE17]
   chk_drive_copy: assert property (@(posedge ref_clk_i) disable iff
      (!resetn_i) wr_i.we && wr_i.addr == blo_pkg::ADDR_DRIVE ##2 1'b1
      |-> data_drive_o == $past(wr_i.data[7:6], 2)) else $error("drive"); // [RULE21]
   chk_coast_src: assert property (@(posedge ref_clk_i) disable iff
      (!resetn_i) coast_r.coast_source_sel && $stable(coast_r)
      |=> coast_in_o == $past(sv_s[1])) else $error("coast source"); // [RULE14]
   chk_hold_frame: assert property (@(posedge ref_clk_i) disable iff
      (!resetn_i) !servo_r.servo_disable && servo_r.frame_update
      && !vs_rise && $stable(servo_r) |=> $stable(corr_r[0]))
      else $error("correction moved off frame"); // [RULE12]
endmodule : blo_ctrl

// *** blo_host_model.sv ***
`timescale 1ns/100ps
module blo_host_model (
   // Clock.
   input wire logic ref_clk_i,
   // Register port toward the block.
   output blo_pkg::blo_wr_t wr_o,
   output logic [7:0] rd_addr_o,
   input wire logic [7:0] rd_data_i
);
   initial begin
      wr_o = '0;
      rd_addr_o = 8'h00;
   end
   // Between strobes the address and data lines carry the inverse of the
   // last transfer, so a block that samples them without the strobe shows it.
   task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
      @(negedge ref_clk_i);
      wr_o = '{we: 1'b1, addr: addr, data: data};
      @(negedge ref_clk_i);
      wr_o = '{we: 1'b0, addr: ~addr, data: ~data};
   endtask : write_reg
   // Pair k covers trims 0 to 2 and targets 3 to 5; high goes out first.
   task automatic write_pair(input int k, input logic [8:0] val);
      logic [7:0] base;
      base = 8'(blo_pkg::ADDR_TRIM_FIRST + 8'(2 * k));
      write_reg(base, {7'h00, val[8]});
      write_reg(8'(base + 8'h01), val[7:0]);
   endtask : write_pair
   // Every coast write goes out with ones forced into bits four and three,
   // the fixed_ones field, whatever the caller passes in those bits.
   task automatic write_coast(input logic [7:0] cfg);
      write_reg(blo_pkg::ADDR_COAST, cfg | 8'h18);
   endtask : write_coast
   // A clamp-only count that is not below the clamp length is pulled in.
   task automatic write_clamp_only(input logic [7:0] m, input logic [7:0] len);
      logic [7:0] v;
      v = (m != 8'h00 && m >= len) ? 8'(len - 8'h01) : m;
      write_reg(blo_pkg::ADDR_CLAMP_ONLY, v);
   endtask : write_clamp_only
   task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
      @(negedge ref_clk_i);
      rd_addr_o = addr;
      @(negedge ref_clk_i);
      data = rd_data_i;
   endtask : read_reg
endmodule : blo_host_model

// *** blo_pkg.sv ***
package blo_pkg;
   localparam logic [7:0] ADDR_TRIM_FIRST = 8'h17;
   localparam logic [7:0] ADDR_TRIM_LAST = 8'h1c;
   localparam logic [7:0] ADDR_TGT_FIRST = 8'h1d;
   localparam logic [7:0] ADDR_TGT_LAST = 8'h22;
   localparam logic [7:0] ADDR_SERVO = 8'h23;
   localparam logic [7:0] ADDR_COAST = 8'h24;
   localparam logic [7:0] ADDR_CLAMP_ONLY = 8'h25;
   localparam logic [7:0] ADDR_CPRE = 8'h26;
   localparam logic [7:0] ADDR_CPOST = 8'h27;
   localparam logic [7:0] ADDR_DRIVE = 8'h28;
   localparam logic [7:0] ADDR_SETTLE = 8'h29;
   localparam logic [7:0] ADDR_RSV_A = 8'h2a;
   localparam logic [7:0] ADDR_RSV_B = 8'h2b;
   localparam logic [7:0] RST_RSV_A = 8'h39;
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [8:0] TRIM_CENTER = 9'h0ff;
   localparam logic [7:0] RST_COAST = 8'h18;
   localparam int FRAME_UPDATES = 64;
   localparam int FCNT_W = 6;
   localparam logic [8:0] TGT_MIN_LO = 9'h1f0;
   localparam logic [8:0] TGT_MIN_HI = 9'h050;
   localparam logic [8:0] TGT_CTR_LO = 9'h1e0;
   localparam logic [8:0] TGT_CTR_HI = 9'h01c;
   // Center clamp level of 128 expressed in quarter LSB.
   localparam logic [11:0] CTR_LEVEL_Q = 12'h200;
   // Servo control fields.
   typedef struct packed {
      logic [2:0] servo_bandwidth_sel;
      logic [1:0] coring_range;
      logic servo_disable;
      logic servo_freeze;
      logic frame_update;
   } blo_servo_t;
   // Coast and slicer configuration fields.
   typedef struct packed {
      logic spare;
      logic coast_source_sel;
      logic clamp_bandwidth;
      logic [1:0] fixed_ones;
      logic slicer_out_invert;
      logic slicer_out_source;
      logic powerdown_out_level;
   } blo_coast_t;
   // Drive fields.
   typedef struct packed {
      logic [1:0] data_drive;
      logic [1:0] clock_drive;
      logic [3:0] spare;
   } blo_drive_t;
   // Write strobe bundle from the register port.
   typedef struct packed {
      logic we;
      logic [7:0] addr;
      logic [7:0] data;
   } blo_wr_t;
endpackage : blo_pkg
